// file: core/adc_threshold_scan_control.sv
// Threshold scan control register, event logic and AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module adc_threshold_scan_control #(
  parameter int RESULT_W = 12
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // Converter status
  input  wire logic                conv_enabled,
  input  wire logic                conv_active,
  input  wire logic [2:0]          conversion_trigger_source,
  input  wire logic                seq_done,
  // Conversion result and buffer pair
  input  wire logic                result_valid,
  input  wire logic [RESULT_W-1:0] result,
  input  wire logic [RESULT_W-1:0] buf_lo,
  input  wire logic [RESULT_W-1:0] buf_hi,
  // Converter controls
  output logic                     scan_enable,
  output logic                     low_power_mode,
  output logic                     charge_source_enable,
  output logic                     reference_enable,
  // Result storage
  output logic                     save_strobe,
  output logic [RESULT_W-1:0]      save_data,
  output logic                     match_pulse,
  // Interrupt
  output logic                     irq
);

  localparam int N = scan_ctrl_pkg::EV_COUNT;

  typedef struct packed {
    logic [15:0]         ctrl;
    logic [N-1:0]        status;
    logic [N-1:0]        mask;
    logic                aw_held;
    logic [7:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                match_seen;
    logic                scan_en;
    logic                low_power;
    logic                charge_en;
    logic                ref_en;
    logic                save;
    logic [RESULT_W-1:0] save_data;
    logic                match;
    logic                irq;
  } state_type;

  state_type s_q;
  state_type s_d;

  match_if #(.W(RESULT_W)) m ();

  compare_unit #(
    .W (RESULT_W)
  ) u_compare (
    .aclk    (aclk),
    .aresetn (aresetn),
    .m       (m.unit)
  );

  // Two-bit field of the control word
  function automatic logic [1:0] field2(input logic [15:0] c, input int lsb);
    field2 = c[lsb +: 2];
  endfunction

  // Field views of the live control value
  // Decoded once so every consumer sees the same registered word
  logic       scan_bit;
  logic       low_power_bit;
  logic       charge_bit;
  logic       ref_bit;
  logic [1:0] irq_mode;
  logic [1:0] write_mode;
  logic [1:0] criterion;
  logic       trigger_ok;
  logic       scanning;

  assign scan_bit      = s_q.ctrl[scan_ctrl_pkg::SCAN_EN_BIT];
  assign low_power_bit = s_q.ctrl[scan_ctrl_pkg::LOW_POWER_BIT];
  assign charge_bit    = s_q.ctrl[scan_ctrl_pkg::CHARGE_REQ_BIT];
  assign ref_bit       = s_q.ctrl[scan_ctrl_pkg::REF_REQ_BIT];
  assign irq_mode      = field2(s_q.ctrl, scan_ctrl_pkg::IRQ_MODE_LSB);
  assign write_mode    = field2(s_q.ctrl, scan_ctrl_pkg::WRITE_MODE_LSB);
  assign criterion     = field2(s_q.ctrl, scan_ctrl_pkg::CRITERION_LSB);
  assign trigger_ok    = conversion_trigger_source == scan_ctrl_pkg::AUTO_CONVERT_SRC;
  // Scan is held off under any other trigger source
  assign scanning      = scan_bit && trigger_ok;

  assign m.valid     = result_valid;
  assign m.result    = result;
  assign m.lo        = buf_lo;
  assign m.hi        = buf_hi;
  assign m.criterion = criterion;

  // Byte-lane merge for a register of up to 32 bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == scan_ctrl_pkg::CTRL_OFFSET) || (a == scan_ctrl_pkg::STATUS_OFFSET) ||
             (a == scan_ctrl_pkg::MASK_OFFSET);
  endfunction

  // Register read multiplexer; reads have no side effect
  function automatic logic [31:0] read_word(input logic [7:0] a, input logic [15:0] c,
                                            input logic [N-1:0] st, input logic [N-1:0] mk);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      scan_ctrl_pkg::CTRL_OFFSET:   r = {16'h0000, c};
      scan_ctrl_pkg::STATUS_OFFSET: r = {{(32-N){1'b0}}, st};
      scan_ctrl_pkg::MASK_OFFSET:   r = {{(32-N){1'b0}}, mk};
      default:                      r = 32'h0000_0000;
    endcase
    read_word = r;
  endfunction

  // Whether a finished conversion is written to its buffer
  function automatic logic save_wanted(input logic [1:0] wm, input logic now_hit);
    logic r;
    r = 1'b0;
    unique case (wm)
      scan_ctrl_pkg::WM_LEGACY:       r = 1'b1;
      scan_ctrl_pkg::WM_SAVE_MATCH:   r = now_hit;
      scan_ctrl_pkg::WM_COMPARE_ONLY: r = 1'b0;
      // Reserved code stores nothing
      default:                        r = 1'b0;
    endcase
    save_wanted = r;
  endfunction

  // Scan interrupt condition chosen by the irq mode field
  function automatic logic scan_irq_event(input logic [1:0] mode, input logic seq_end,
                                          input logic seen, input logic now_hit);
    logic r;
    r = 1'b0;
    unique case (mode)
      scan_ctrl_pkg::IRQ_DONE_MATCH: r = seq_end && (seen || now_hit);
      scan_ctrl_pkg::IRQ_MATCH:      r = now_hit;
      scan_ctrl_pkg::IRQ_DONE:       r = seq_end;
      default:                       r = 1'b0;
    endcase
    scan_irq_event = r;
  endfunction

  always_comb begin
    logic          aw_take;
    logic          w_take;
    logic          aw_have;
    logic          w_have;
    logic [7:0]    waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [31:0]   merged;
    logic [N-1:0]  events;
    logic [N-1:0]  clear;
    logic          hit;
    logic          done;
    aw_take = 1'b0;
    w_take  = 1'b0;
    aw_have = 1'b0;
    w_have  = 1'b0;
    waddr   = 8'h00;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    merged  = 32'h0000_0000;
    events  = '0;
    clear   = '0;
    hit     = 1'b0;
    done    = 1'b0;
    s_d     = s_q;

    // Write address and data may arrive in either order
    aw_take = s_axi_awvalid && !s_q.aw_held && !s_q.bvalid;
    w_take  = s_axi_wvalid && !s_q.w_held && !s_q.bvalid;
    aw_have = s_q.aw_held || aw_take;
    w_have  = s_q.w_held || w_take;
    waddr   = s_q.aw_held ? s_q.aw_addr : s_axi_awaddr;
    wdata   = s_q.w_held ? s_q.w_data : s_axi_wdata;
    wstrb   = s_q.w_held ? s_q.w_strb : s_axi_wstrb;
    // A lone address or data beat is parked until its partner arrives
    if (aw_take) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (aw_have && w_have && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = mapped(waddr) ? scan_ctrl_pkg::RESP_OKAY : scan_ctrl_pkg::RESP_SLVERR;
      unique case (waddr)
        scan_ctrl_pkg::CTRL_OFFSET: begin
          merged     = merge({16'h0000, s_q.ctrl}, wdata, wstrb);
          s_d.ctrl   = merged[15:0] & scan_ctrl_pkg::CTRL_WRITE_MASK;
        end
        scan_ctrl_pkg::STATUS_OFFSET: begin
          // Write one to clear
          if (wstrb[0]) begin
            clear = wdata[N-1:0];
          end
        end
        scan_ctrl_pkg::MASK_OFFSET: begin
          if (wstrb[0]) begin
            s_d.mask = wdata[N-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Read channel, answer one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = mapped(s_axi_araddr) ? scan_ctrl_pkg::RESP_OKAY
                                        : scan_ctrl_pkg::RESP_SLVERR;
      s_d.rdata  = read_word(s_axi_araddr, s_q.ctrl, s_q.status, s_q.mask);
    end

    // Converter controls
    s_d.scan_en   = scanning;
    s_d.low_power = low_power_bit;
    s_d.charge_en = charge_bit && conv_enabled
                    && conv_active;
    s_d.ref_en    = ref_bit && conv_enabled
                    && conv_active;

    // Threshold compare counts only while scanning
    hit  = m.hit && scanning;
    done = seq_done && scanning;
    s_d.match = hit;

    // Result storage by write mode
    s_d.save = 1'b0;
    // Legacy saving does not depend on the scan state
    if (m.done) begin
      s_d.save      = save_wanted(write_mode, hit);
      s_d.save_data = m.result_q;
    end

    // Match memory for the done-with-match condition
    if (done) begin
      s_d.match_seen = 1'b0;
    end else if (hit) begin
      s_d.match_seen = 1'b1;
    end

    // Interrupt condition; a match in the final cycle still counts
    events[scan_ctrl_pkg::EV_SCAN_IRQ] = scan_irq_event(irq_mode, done, s_q.match_seen,
                                                        hit);
    events[scan_ctrl_pkg::EV_MATCH]       = hit;
    events[scan_ctrl_pkg::EV_SEQ_DONE]    = done;
    // Flags software that enabled scan under a wrong trigger source
    events[scan_ctrl_pkg::EV_BAD_TRIGGER] =
      scan_bit && !trigger_ok;

    // Set wins over a simultaneous clear
    s_d.status = (s_q.status & ~clear) | events;
    s_d.irq    = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q        <= '0;
      s_q.ctrl   <= scan_ctrl_pkg::CTRL_RESET;
      s_q.status <= scan_ctrl_pkg::STATUS_RESET;
      s_q.mask   <= scan_ctrl_pkg::MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready        = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready         = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid         = s_q.bvalid;
  assign s_axi_bresp          = s_q.bresp;
  assign s_axi_arready        = !s_q.rvalid;
  assign s_axi_rvalid         = s_q.rvalid;
  assign s_axi_rdata          = s_q.rdata;
  assign s_axi_rresp          = s_q.rresp;
  assign scan_enable          = s_q.scan_en;
  assign low_power_mode       = s_q.low_power;
  assign charge_source_enable = s_q.charge_en;
  assign reference_enable     = s_q.ref_en;
  assign save_strobe          = s_q.save;
  assign save_data            = s_q.save_data;
  assign match_pulse          = s_q.match;
  assign irq                  = s_q.irq;

endmodule // adc_threshold_scan_control
`default_nettype wire

// file: core/compare_unit.sv
// Registered match evaluation of one conversion result
`timescale 1ns/1ps
`default_nettype none
module compare_unit #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Result and buffer pair
  match_if.unit     m
);

  typedef struct packed {
    logic         done;
    logic         hit;
    logic [W-1:0] result;
  } state_type;

  state_type s_q;
  state_type s_d;

  function automatic logic inside_pair(input logic [W-1:0] r, input logic [W-1:0] a,
                                       input logic [W-1:0] b);
    inside_pair = (r >= a) && (r <= b);
  endfunction

  always_comb begin
    s_d      = s_q;
    s_d.done = m.valid;
    if (m.valid) begin
      s_d.result = m.result;
      unique case (m.criterion)
        scan_ctrl_pkg::CM_OUTSIDE: s_d.hit = !inside_pair(m.result, m.lo, m.hi);
        scan_ctrl_pkg::CM_INSIDE:  s_d.hit = inside_pair(m.result, m.lo, m.hi);
        scan_ctrl_pkg::CM_GREATER: s_d.hit = m.result > m.lo;
        default:                   s_d.hit = m.result < m.lo;
      endcase
    end else begin
      s_d.hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign m.done     = s_q.done;
  assign m.hit      = s_q.hit;
  assign m.result_q = s_q.result;

endmodule // compare_unit
`default_nettype wire

// file: core/match_if.sv
// Carrier between the control core and the compare unit
`timescale 1ns/1ps
`default_nettype none
interface match_if #(parameter int W = 12);
  logic         valid;
  logic [W-1:0] result;
  logic [W-1:0] lo;
  logic [W-1:0] hi;
  logic [1:0]   criterion;
  logic         done;
  logic         hit;
  logic [W-1:0] result_q;
  modport unit (input valid, result, lo, hi, criterion, output done, hit, result_q);
  modport core (output valid, result, lo, hi, criterion, input done, hit, result_q);
endinterface
`default_nettype wire

// file: core/scan_ctrl_pkg.sv
// Constants, field layout and register map of the threshold scan control block
// Contract
// - Scan enable bit turns auto-scan on; only valid with trigger source seven.
// - Low-power select set gives low-power mode, clear gives full power.
// - Charge source request enables charge-time source while converter enabled and active.
// - Reference request enables band-gap reference while converter enabled and active.
// - Irq mode: 11 done-with-match, 10 match, 01 done, 00 none.
// - Write mode: 10 compare only, 01 save on match, 00 always save.
// - Criterion: 11 outside window, 10 inside window, greater-than mode exceeds buffer.
package scan_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]  MASK_OFFSET     = 8'h08;

  // Control register fields
  localparam int          SCAN_EN_BIT     = 15;
  localparam int          LOW_POWER_BIT   = 14;
  localparam int          CHARGE_REQ_BIT  = 13;
  localparam int          REF_REQ_BIT     = 12;
  localparam int          IRQ_MODE_LSB    = 8;
  localparam int          WRITE_MODE_LSB  = 2;
  localparam int          CRITERION_LSB   = 0;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  // Reserved bit 11 held at zero, unimplemented bits read zero
  localparam logic [15:0] CTRL_WRITE_MASK = 16'hf30f;

  // Field encodings
  localparam logic [1:0]  IRQ_DONE_MATCH  = 2'h3;
  localparam logic [1:0]  IRQ_MATCH       = 2'h2;
  localparam logic [1:0]  IRQ_DONE        = 2'h1;
  localparam logic [1:0]  WM_COMPARE_ONLY = 2'h2;
  localparam logic [1:0]  WM_SAVE_MATCH   = 2'h1;
  localparam logic [1:0]  WM_LEGACY       = 2'h0;
  localparam logic [1:0]  CM_OUTSIDE      = 2'h3;
  localparam logic [1:0]  CM_INSIDE       = 2'h2;
  localparam logic [1:0]  CM_GREATER      = 2'h1;
  localparam logic [2:0]  AUTO_CONVERT_SRC = 3'h7;

  // Status and mask bit positions
  localparam int          EV_SCAN_IRQ     = 0;
  localparam int          EV_MATCH        = 1;
  localparam int          EV_SEQ_DONE     = 2;
  localparam int          EV_BAD_TRIGGER  = 3;
  localparam int          EV_COUNT        = 4;
  localparam logic [3:0]  STATUS_RESET    = 4'h0;
  localparam logic [3:0]  MASK_RESET      = 4'h0;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// file: testbench/adc_threshold_scan_control_properties.sv
// Port-level timing checks for the threshold scan control block
`timescale 1ns/1ps
`default_nettype none
module adc_threshold_scan_control_props #(
  parameter int RESULT_W = 12
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Register bus answers
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_rvalid,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic [31:0]         s_axi_rdata,
  // Converter side
  input wire logic                conv_enabled,
  input wire logic                conv_active,
  input wire logic [2:0]          conversion_trigger_source,
  input wire logic                result_valid,
  input wire logic [RESULT_W-1:0] result,
  input wire logic                scan_enable,
  input wire logic                charge_source_enable,
  input wire logic                reference_enable,
  input wire logic                save_strobe,
  input wire logic [RESULT_W-1:0] save_data,
  input wire logic                match_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_scan;
    scan_enable |-> $past(conversion_trigger_source) == 3'h7;
  endproperty
  a_scan: assert property (p_scan) else $error("scan on without auto-convert");
  property p_match_trig;
    match_pulse |-> $past(conversion_trigger_source) == 3'h7;
  endproperty
  a_match_trig: assert property (p_match_trig) else $error("match outside scan");
  property p_charge;
    charge_source_enable |-> $past(conv_enabled && conv_active);
  endproperty
  a_charge: assert property (p_charge) else $error("charge source while idle");
  property p_ref;
    reference_enable |-> $past(conv_enabled && conv_active);
  endproperty
  a_ref: assert property (p_ref) else $error("reference while idle");
  property p_match_src;
    match_pulse |-> $past(result_valid, 2);
  endproperty
  a_match_src: assert property (p_match_src) else $error("match without result");
  property p_save_src;
    save_strobe |-> $past(result_valid, 2);
  endproperty
  a_save_src: assert property (p_save_src) else $error("save without result");
  property p_save_data;
    save_strobe |-> save_data == $past(result, 2);
  endproperty
  a_save_data: assert property (p_save_data) else $error("saved value differs");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer not retired");
  property p_rerr;
    s_axi_rvalid && s_axi_rresp == scan_ctrl_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("refused read carries data");
endmodule // adc_threshold_scan_control_props

bind adc_threshold_scan_control adc_threshold_scan_control_props #(.RESULT_W(RESULT_W)) props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .conv_enabled(conv_enabled), .conv_active(conv_active),
  .conversion_trigger_source(conversion_trigger_source), .result_valid(result_valid),
  .result(result), .scan_enable(scan_enable), .charge_source_enable(charge_source_enable),
  .reference_enable(reference_enable), .save_strobe(save_strobe), .save_data(save_data),
  .match_pulse(match_pulse)
);
`default_nettype wire

// file: testbench/adc_threshold_scan_control_tb_top.sv
// Self-checking bench for the threshold scan control block
`timescale 1ns/1ps
`default_nettype none
module adc_threshold_scan_control_tb_top;
  logic        aclk, aresetn, seq_done, result_valid, conv_enabled, conv_active;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, m_seen, s_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  conversion_trigger_source;
  logic [11:0] result, buf_lo, buf_hi, save_data, sd_seen;
  logic        scan_enable, low_power_mode, charge_source_enable, reference_enable;
  logic        save_strobe, match_pulse, irq;
  int          fail_count, compares, cycles;

  adc_threshold_scan_control dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_enabled, .conv_active,
    .conversion_trigger_source, .seq_done, .result_valid, .result, .buf_lo, .buf_hi,
    .scan_enable, .low_power_mode, .charge_source_enable, .reference_enable, .save_strobe,
    .save_data, .match_pulse, .irq);

  always #2 aclk = ~aclk;

  // Ceiling far above the several hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic hit_f(input logic [1:0] c, input logic [11:0] r, l, h);
    case (c)
      2'h3: return r < l || r > h;
      2'h2: return r >= l && r <= h;
      2'h1: return r > l;
      default: return r < l;
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One result pulse, then collect whatever it produced
  task automatic conv(input logic [11:0] r);
    @(posedge aclk);
    result_valid <= 1'b1;
    result <= r;
    @(posedge aclk);
    result_valid <= 1'b0;
    m_seen = 0;
    s_seen = 0;
    sd_seen = 0;
    repeat (3) begin
      @(posedge aclk);
      #1;
      m_seen |= match_pulse;
      s_seen |= save_strobe;
      if (save_strobe) sd_seen = save_data;
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  initial begin
    logic [11:0] lo, hi, r;
    logic [1:0]  cm, wm;
    logic        h, e;
    aclk = 0;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {conv_enabled, conv_active, seq_done, result_valid} = 4'h0;
    conversion_trigger_source = 3'h0;
    {result, buf_lo, buf_hi} = 36'h0;
    rnd = 32'h00016962;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdr(8'(i * 4));
      chk("reset value", rd, 32'h0);
    end
    repeat (6) begin
      rnd = lfsr(rnd);
      wr(8'h00, rnd);
      chk("bresp ok", rsp, scan_ctrl_pkg::RESP_OKAY);
      rdr(8'h00);
      chk("rresp ok", rsp, scan_ctrl_pkg::RESP_OKAY);
      chk("ctrl", rd, {16'h0, rnd[15:0] & scan_ctrl_pkg::CTRL_WRITE_MASK});
      chk("low power", low_power_mode, rnd[14]);
    end
    wr(8'h0c, 32'hffffffff);
    chk("bresp", rsp, scan_ctrl_pkg::RESP_SLVERR);
    rdr(8'h0c);
    chk("rresp", rsp, scan_ctrl_pkg::RESP_SLVERR);
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      if (i[1:0] == 2'h0) wr(8'h00, i[2] ? 32'h1000 : 32'h2000);
      @(posedge aclk);
      conv_enabled <= i[0];
      conv_active <= i[1];
      settle();
      chk("charge", charge_source_enable, !i[2] && i[0] && i[1]);
      chk("reference", reference_enable, i[2] && i[0] && i[1]);
    end
    wr(8'h00, 32'h8000);
    for (int t = 0; t < 8; t++) begin
      @(posedge aclk);
      conversion_trigger_source <= t[2:0];
      settle();
      chk("scan", scan_enable, t == 7);
    end
    rdr(8'h04);
    chk("bad trigger", rd[3], 1'b1);
    $display("controls done");
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      cm = i[1:0];
      wm = i[3:2];
      lo = rnd[11:0] < rnd[23:12] ? rnd[11:0] : rnd[23:12];
      hi = rnd[11:0] < rnd[23:12] ? rnd[23:12] : rnd[11:0];
      r = i % 3 == 0 ? lo : (i % 3 == 1 ? hi : rnd[31:20]);
      wr(8'h00, {16'h0, 4'h8, 8'h0, wm, cm});
      @(posedge aclk);
      buf_lo <= lo;
      buf_hi <= hi;
      conv(r);
      h = hit_f(cm, r, lo, hi);
      chk("match", m_seen, h);
      chk("save", s_seen, wm == 2'h0 || (wm == 2'h1 && h));
      if (s_seen) chk("save data", sd_seen, r);
    end
    wr(8'h00, 32'h0);
    conv(12'h5a5);
    chk("legacy idle", {m_seen, s_seen}, 2'h1);
    $display("compare done");
    wr(8'h08, 32'h1);
    // Upper half misses, so done-with-match mode must stay quiet
    for (int m = 0; m < 8; m++) begin
      h = !m[2];
      e = m[1:0] == 2'h1 || (m[1] && h);
      wr(8'h04, 32'hf);
      wr(8'h00, {16'h0, 4'h8, 2'h0, m[1:0], 8'h02});
      @(posedge aclk);
      buf_lo <= h ? 12'h000 : 12'h200;
      buf_hi <= 12'hfff;
      conv(12'h123);
      chk("irq on match", irq, m[1:0] == 2'h2 && h);
      @(posedge aclk);
      seq_done <= 1'b1;
      @(posedge aclk);
      seq_done <= 1'b0;
      settle();
      chk("irq on done", irq, e);
      rdr(8'h04);
      chk("status", rd, {29'h0, 1'b1, h, e});
      wr(8'h08, 32'h0);
      settle();
      chk("irq masked", irq, 1'b0);
      wr(8'h08, 32'h1);
      settle();
      chk("irq unmasked", irq, e);
      wr(8'h04, 32'h1);
      settle();
      chk("irq cleared", irq, 1'b0);
    end
    $display("interrupts done");
    // Mid-run reset must bring the control and mask registers back to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00);
    chk("reset ctrl", rd, 32'h0);
    rdr(8'h08);
    chk("reset mask", rd, 32'h0);
    chk("reset irq", irq, 1'b0);
    $display("reset done");
    end_sim();
  end
endmodule // adc_threshold_scan_control_tb_top
`default_nettype wire
